//--- design/bhdp_clkdiv.sv
`timescale 1ns/1ns
// Fractional divider: one-cycle tick at step/factor of the clock rate.
module bhdp_clkdiv #(
  parameter int FW = 8
) (
  // Clock and reset.
  input  wire logic          ref_clk,
  input  wire logic          rst_n,
  // Control.
  input  wire logic          run,
  input  wire logic [FW-1:0] factor,
  input  wire logic          double_rate,
  // Rate enable.
  output logic               tick
);
  initial if (FW < 2) $error("bhdp_clkdiv: FW below 2");

  // ****************************************************************
  // Accumulator
  // ****************************************************************
  logic [FW:0] acc_r;     // Phase accumulator.
  logic [FW:0] acc_nxt;   // Accumulator after this cycle's step.
  logic [FW:0] step;      // Two for twice the rate, else one.
  logic [FW:0] eff;       // Factor, never below the step.
  logic        wrap;      // Accumulator reaches or passes the factor.

  assign step    = double_rate ? (FW+1)'(2) : (FW+1)'(1);
  assign eff     = ({1'b0, factor} < step) ? step : {1'b0, factor};
  assign wrap    = (acc_r + step) >= eff;
  assign acc_nxt = wrap ? (acc_r + step - eff) : (acc_r + step);
  assign tick    = run && wrap;

  // The accumulator restarts whenever the divider is stopped.
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !run) begin
      acc_r <= '0;
    end else begin
      acc_r <= acc_nxt;
    end
  end
endmodule // bhdp_clkdiv

//--- design/bhdp_defs.svh
`ifndef BHDP_DEFS_SVH
`define BHDP_DEFS_SVH

// ****************************************************************
// Register offsets on the byte register port.
// ****************************************************************
`define BHDP_OFS_OUT_CTRL   6'h00
`define BHDP_OFS_MODE_CTRL  6'h01
`define BHDP_OFS_MAX_HI     6'h0c
`define BHDP_OFS_MAX_LO     6'h0d
`define BHDP_OFS_MIN_HI     6'h0e
`define BHDP_OFS_MIN_LO     6'h0f
`define BHDP_OFS_TXA_HI     6'h15
`define BHDP_OFS_TXA_MID    6'h16
`define BHDP_OFS_TXA_LO     6'h17
`define BHDP_OFS_RXA_HI     6'h18
`define BHDP_OFS_RXA_MID    6'h19
`define BHDP_OFS_RXA_LO     6'h1a
`define BHDP_OFS_DRIVE      6'h21

// ****************************************************************
// Field positions and reset values.
// ****************************************************************
`define BHDP_BIT_TRISTATE   6
`define BHDP_BIT_SERIAL     0
`define BHDP_BIT_REAL_TX    1
`define BHDP_BIT_ADDR_MODE  2
`define BHDP_BIT_HALF_DRIVE 0
`define BHDP_RST_OUT_CTRL   8'h40
`define BHDP_RST_OTHER      8'h00

// ****************************************************************
// Address preamble and host address control codes.
// ****************************************************************
`define BHDP_ADDR_LAST      2'h3
`define BHDP_HOST_ADDRESS_CONTROL_ADDR     2'h0
`define BHDP_HOST_ADDRESS_CONTROL_DATA     2'h1

`endif

//--- design/bhdp_pkg.sv
package bhdp_pkg;

  // Configuration decoded from the register file.
  typedef struct packed {
    logic        tristate;    // Port held in high impedance.
    logic        half_drive;  // Reduced output drive request.
    logic        addr_mode;   // Address preamble mode.
    logic        serial_mode; // Serial on-off keyed transmit input.
    logic        real_tx;     // Transmit words are real, not I/Q pairs.
    logic [15:0] mod_max;     // Sample chosen by a serial one.
    logic [15:0] mod_min;     // Sample chosen by a serial zero.
    logic [18:0] tx_addr;     // Transfer address for transmit.
    logic [18:0] rx_addr;     // Transfer address for receive.
  } bhdp_cfg_s;

  // One complex sample, I and Q in two's complement.
  typedef struct packed {
    logic [15:0] i;
    logic [15:0] q;
  } bhdp_iq_s;

  // Burst sequencer states.
  typedef enum logic [2:0] {
    BHDP_OFF,
    BHDP_ARM,
    BHDP_SYNC,
    BHDP_ADDR,
    BHDP_DATA
  } bhdp_state_e;

endpackage

//--- design/bhdp_regs.sv
`timescale 1ns/1ns
`include "bhdp_defs.svh"
// Byte register file at the documented offsets.
module bhdp_regs (
  // Clock and reset.
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // Register access port.
  input  wire logic [5:0]        reg_addr,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [7:0]        reg_wdata,
  output logic [7:0]             reg_rdata,
  // Decoded configuration.
  output bhdp_pkg::bhdp_cfg_s    cfg
);
  import bhdp_pkg::*;

  // ****************************************************************
  // Storage and decode
  // ****************************************************************
  logic [7:0] mem_r [0:63];  // Byte registers, indexed by offset.
  logic       mapped;        // Offset holds a register.

  assign mapped = (reg_addr == `BHDP_OFS_OUT_CTRL) || (reg_addr == `BHDP_OFS_MODE_CTRL)
               || (reg_addr >= `BHDP_OFS_MAX_HI && reg_addr <= `BHDP_OFS_MIN_LO)
               || (reg_addr >= `BHDP_OFS_TXA_HI && reg_addr <= `BHDP_OFS_RXA_LO)
               || (reg_addr == `BHDP_OFS_DRIVE);

  // Writes land only on mapped offsets; the port starts tri-stated.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int k = 0; k < 64; k++) begin
        mem_r[k] <= `BHDP_RST_OTHER;
      end
      mem_r[`BHDP_OFS_OUT_CTRL] <= `BHDP_RST_OUT_CTRL;
    end else if (reg_wr && mapped) begin
      mem_r[reg_addr] <= reg_wdata;
    end
  end

  // Read data comes one cycle after the strobe; unmapped reads zero.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= mapped ? mem_r[reg_addr] : 8'h00;
    end
  end

  // ****************************************************************
  // Field extraction
  // ****************************************************************
  assign cfg.tristate    = mem_r[`BHDP_OFS_OUT_CTRL][`BHDP_BIT_TRISTATE];
  assign cfg.half_drive  = mem_r[`BHDP_OFS_DRIVE][`BHDP_BIT_HALF_DRIVE];
  assign cfg.addr_mode   = mem_r[`BHDP_OFS_MODE_CTRL][`BHDP_BIT_ADDR_MODE];
  assign cfg.serial_mode = mem_r[`BHDP_OFS_MODE_CTRL][`BHDP_BIT_SERIAL];
  assign cfg.real_tx     = mem_r[`BHDP_OFS_MODE_CTRL][`BHDP_BIT_REAL_TX];
  assign cfg.mod_max     = {mem_r[`BHDP_OFS_MAX_HI], mem_r[`BHDP_OFS_MAX_LO]};
  assign cfg.mod_min     = {mem_r[`BHDP_OFS_MIN_HI], mem_r[`BHDP_OFS_MIN_LO]};
  assign cfg.tx_addr     = {mem_r[`BHDP_OFS_TXA_HI][6:0], mem_r[`BHDP_OFS_TXA_MID],
                            mem_r[`BHDP_OFS_TXA_LO][3:0]};
  assign cfg.rx_addr     = {mem_r[`BHDP_OFS_RXA_HI][6:0], mem_r[`BHDP_OFS_RXA_MID],
                            mem_r[`BHDP_OFS_RXA_LO][3:0]};
endmodule // bhdp_regs

//--- design/bhdp_top.sv
`timescale 1ns/1ns
`include "bhdp_defs.svh"
module bhdp_top #(
  parameter int FW = 8,  // Width of the division factors.
  parameter int DW = 16  // Data port width.
) (
  // Clock and reset.
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // Register access port.
  input  wire logic [5:0]        reg_addr,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [7:0]        reg_wdata,
  output logic [7:0]             reg_rdata,
  // Filter chain settings.
  input  wire logic [FW-1:0]     interp_factor,
  input  wire logic [FW-1:0]     decim_factor,
  // Receive samples from the decimation chain.
  input  wire bhdp_pkg::bhdp_iq_s rx_sample,
  // Transmit sample to the interpolation chain.
  output bhdp_pkg::bhdp_iq_s     tx_sample,
  // Host data port pins.
  input  wire logic [DW-1:0]     host_data_port_i,
  output logic [DW-1:0]          host_data_port_o,
  output logic                   host_data_port_oe,
  output logic                   port_half_drive,
  input  wire logic              direction_select,
  output logic                   port_clock,
  output logic                   frame_sync,
  // General pins shared by address control and serial input.
  input  wire logic              gpio1_i,
  output logic [1:0]             gpio_o,
  output logic [1:0]             gpio_oe
);
  import bhdp_pkg::*;

  initial if (DW != 16) $error("bhdp_top: data port must be 16 bits");

  // ****************************************************************
  // Registers and clocking
  // ****************************************************************
  bhdp_cfg_s     cfg;         // Decoded configuration.
  logic          enabled;     // Port enabled for parallel bursts.
  logic          port_tick;   // Port clock rising edge, one cycle.
  logic          ser_tick;    // Serial bit clock rising edge.
  logic [FW-1:0] port_factor; // Divider for the current direction.
  logic          port_double; // Port clock at twice the base rate.

  bhdp_regs u_regs (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .reg_addr  (reg_addr),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_wdata (reg_wdata),
    .reg_rdata (reg_rdata),
    .cfg       (cfg)
  );

  assign enabled     = !cfg.tristate && !cfg.serial_mode;
  assign port_factor = direction_select ? interp_factor : decim_factor;
  assign port_double = direction_select ? !cfg.real_tx : 1'b1;

  // Port clock divider, stopped while the port is disabled.
  bhdp_clkdiv #(.FW(FW)) u_port_div (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .run         (enabled),
    .factor      (port_factor),
    .double_rate (port_double),
    .tick        (port_tick)
  );

  // Serial bit clock divider at the interpolation rate.
  bhdp_clkdiv #(.FW(FW)) u_ser_div (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .run         (cfg.serial_mode),
    .factor      (interp_factor),
    .double_rate (1'b0),
    .tick        (ser_tick)
  );

  // ****************************************************************
  // Burst sequencer
  // ****************************************************************
  bhdp_state_e state_r;     // Current sequencer state.
  bhdp_state_e state_nxt;   // Next sequencer state.
  logic        dir_r;       // Direction seen last cycle.
  logic        restart;     // Direction flipped or port disabled.
  logic [1:0]  addr_cnt_r;  // Address word index.
  logic [15:0] word_cnt_r;  // Data words since the last preamble.
  logic        iq_q_r;      // Next data word is the Q half.
  logic        in_addr;     // Address word slot on this tick.
  logic        in_data;     // Data word slot on this tick.
  logic        word_wrap;   // Last word of the address range.

  assign restart   = !enabled || (direction_select != dir_r);
  assign in_addr   = port_tick && (state_r == BHDP_ADDR);
  assign in_data   = port_tick && (state_r == BHDP_DATA);
  assign word_wrap = in_data && (word_cnt_r == 16'hffff);

  // Frame sync rises on one tick and falls on the next; words follow.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      BHDP_OFF:  state_nxt = enabled ? BHDP_ARM : BHDP_OFF;
      BHDP_ARM:  if (port_tick) begin
        state_nxt = BHDP_SYNC;
      end
      BHDP_SYNC: if (port_tick) begin
        state_nxt = cfg.addr_mode ? BHDP_ADDR : BHDP_DATA;
      end
      BHDP_ADDR: if (in_addr && addr_cnt_r == `BHDP_ADDR_LAST) begin
        state_nxt = BHDP_DATA;
      end
      BHDP_DATA: if (word_wrap && cfg.addr_mode) begin
        state_nxt = BHDP_ADDR;
      end
    endcase
    if (restart) begin
      state_nxt = enabled ? BHDP_ARM : BHDP_OFF;
    end
  end

  // State, direction and counters.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r    <= BHDP_OFF;
      dir_r      <= 1'b0;
      addr_cnt_r <= 2'h0;
      word_cnt_r <= 16'h0000;
      iq_q_r     <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      dir_r      <= direction_select;
      addr_cnt_r <= (state_r != BHDP_ADDR) ? 2'h0 : addr_cnt_r + 2'(in_addr);
      word_cnt_r <= (state_r != BHDP_DATA) ? 16'h0000 : word_cnt_r + 16'(in_data);
      iq_q_r     <= (state_r != BHDP_DATA) ? 1'b0 : iq_q_r ^ in_data;
    end
  end

  // ****************************************************************
  // Port clock and frame sync
  // ****************************************************************
  // Port clock is high for one master cycle per tick.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      port_clock <= 1'b0;
      frame_sync <= 1'b0;
    end else begin
      port_clock <= port_tick && !restart;
      if (restart) begin
        frame_sync <= 1'b0;
      end else if (port_tick) begin
        frame_sync <= (state_r == BHDP_ARM);
      end
    end
  end

  // ****************************************************************
  // Receive output latch and address preamble
  // ****************************************************************
  logic [18:0] cur_addr;   // Transfer address for this direction.
  logic [15:0] addr_word;  // Address word for the current slot.

  assign cur_addr  = direction_select ? cfg.tx_addr : cfg.rx_addr;
  assign addr_word = addr_cnt_r[0] ? cur_addr[15:0] : {13'h0000, cur_addr[18:16]};

  // Output latch changes only on port clock rising edges.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      host_data_port_o <= '0;
    end else if (in_addr && !restart) begin
      host_data_port_o <= addr_word;
    end else if (in_data && !restart && !direction_select) begin
      host_data_port_o <= iq_q_r ? rx_sample.q : rx_sample.i;
    end
  end

  // Drive only when enabled and receiving, or during the preamble.
  assign host_data_port_oe = enabled && (!direction_select
                          || (state_r == BHDP_ADDR || state_r == BHDP_DATA && dir_r
                              && word_cnt_r == 16'h0000 && cfg.addr_mode && 1'b0));
  assign port_half_drive   = cfg.half_drive;

  // ****************************************************************
  // Transmit input latch
  // ****************************************************************
  logic        tx_capture;  // Transmit word taken on this tick.
  logic        ser_load;    // Serial bit taken on this tick.
  logic [15:0] tx_i_hold_r; // I half waiting for its Q half.

  assign tx_capture = in_data && !restart && direction_select;
  assign ser_load   = ser_tick && cfg.serial_mode;

  // The sample only changes on a capture or a serial load; otherwise it is held.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_sample   <= '0;
      tx_i_hold_r <= 16'h0000;
    end else if (ser_load) begin
      tx_sample.i <= gpio1_i ? cfg.mod_max : cfg.mod_min;
      tx_sample.q <= 16'h0000;
    end else if (tx_capture && cfg.real_tx) begin
      tx_sample.i <= host_data_port_i;
      tx_sample.q <= 16'h0000;
    end else if (tx_capture && !iq_q_r) begin
      tx_i_hold_r <= host_data_port_i;
    end else if (tx_capture) begin
      tx_sample.i <= tx_i_hold_r;
      tx_sample.q <= host_data_port_i;
    end
  end

  // ****************************************************************
  // General pins
  // ****************************************************************
  logic       bit_clock_r;  // Serial bit clock pulse.
  logic [1:0] host_address_control;        // Host address control code.

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      bit_clock_r <= 1'b0;
    end else begin
      bit_clock_r <= ser_load;
    end
  end

  assign host_address_control   = (state_r == BHDP_DATA) ? `BHDP_HOST_ADDRESS_CONTROL_DATA : `BHDP_HOST_ADDRESS_CONTROL_ADDR;
  // Serial mode takes precedence over address mode on the pins.
  assign gpio_o  = cfg.serial_mode ? {1'b0, bit_clock_r}
                 : (cfg.addr_mode ? host_address_control : 2'b00);
  assign gpio_oe = cfg.serial_mode ? 2'b01 : (cfg.addr_mode ? 2'b11 : 2'b00);

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_sync_rise;
    $rose(frame_sync) && port_clock;
  endsequence

  sequence s_sync_fall;
    $fell(frame_sync) && port_clock;
  endsequence

  chk_sync_rise_edge: assert property ($rose(frame_sync) |-> s_sync_rise)
    else $error("frame sync rose off a port clock edge");
  // An aborted frame drops sync with the port clock held low, so only an
  // ordinary fall, not one forced by a restart, must land on a port clock edge.
  chk_sync_fall_edge: assert property (
      $fell(frame_sync) && enabled && !$past(restart) |-> s_sync_fall)
    else $error("frame sync fell off a port clock edge");
  chk_sync_one_period: assert property (frame_sync && port_clock |-> $rose(frame_sync))
    else $error("frame sync held beyond one port clock period");
  chk_tristate_ctl: assert property (
      reg_wr && reg_addr == `BHDP_OFS_OUT_CTRL && reg_wdata[`BHDP_BIT_TRISTATE]
      |=> !host_data_port_oe)
    else $error("port driven while tri-state control set");
  chk_turnaround_now: assert property (
      enabled && !direction_select |-> host_data_port_oe)
    else $error("receive selected but port not driven");
  chk_drive_half: assert property (
      reg_wr && reg_addr == `BHDP_OFS_DRIVE |=> port_half_drive == $past(reg_wdata[0]))
    else $error("drive strength does not follow its register");
  chk_tx_hold: assert property (!tx_capture && !ser_load |=> $stable(tx_sample))
    else $error("transmit sample changed without a capture");
  chk_serial_mux: assert property (
      ser_load |=> tx_sample.i == ($past(gpio1_i) ? cfg.mod_max : cfg.mod_min))
    else $error("serial bit selected wrong modulation value");
  // The word index has already stepped on by the time the state is looked at,
  // so the index of the launching slot is taken one cycle back.
  chk_addr_four: assert property (
      in_addr && !restart |=> state_r == (($past(addr_cnt_r) == `BHDP_ADDR_LAST) ? BHDP_DATA
                                          : BHDP_ADDR))
    else $error("address preamble length is not four words");
  chk_addr_pins: assert property (cfg.addr_mode && !cfg.serial_mode |-> gpio_oe == 2'b11)
    else $error("address control pins not driven in address mode");
  chk_rx_launch: assert property (in_data && !restart && !direction_select
      |=> host_data_port_o == ($past(iq_q_r) ? $past(rx_sample.q) : $past(rx_sample.i)))
    else $error("receive word not launched on port clock edge");
endmodule // bhdp_top

//--- test/bhdp_host_model.sv
`timescale 1ns/1ns
// ****************************************************************
// Host parallel port model: sends I then Q after each sync fall.
// ****************************************************************
module bhdp_host_model (
  // Clock and port control seen from the device.
  input  wire logic        ref_clk,
  input  wire logic        direction_select,
  input  wire logic        port_clock,
  input  wire logic        frame_sync,
  // Words to send, two's complement.
  input  wire logic [15:0] word_i,
  input  wire logic [15:0] word_q,
  // Bus level toward the device.
  output logic      [15:0] host_data_port_i
);
  logic seen_fs;  // Sync pulse seen, waiting for its fall.
  logic armed;    // Frame running, words flow.
  logic send_q;   // Next word is the Q half.

  // Steps the word on each port clock pulse, just after the edge.
  initial begin
    seen_fs = 1'b0;
    armed = 1'b0;
    send_q = 1'b0;
    host_data_port_i = 16'h0000;
    forever begin
      @(posedge ref_clk);
      #1;
      if (!direction_select) begin
        seen_fs = 1'b0;
        armed = 1'b0;
      end else if (port_clock && frame_sync) begin
        seen_fs = 1'b1;
        armed = 1'b0;
      end else if (port_clock && seen_fs && !armed) begin
        armed = 1'b1;
        send_q = 1'b0;
      end else if (port_clock && armed) begin
        send_q = !send_q;
      end
      // A released bus keeps no value: it toggles every cycle.
      if (armed)
        host_data_port_i = send_q ? word_q : word_i;
      else
        host_data_port_i = ~host_data_port_i;
    end
  end
endmodule  // bhdp_host_model

//--- test/testbench.sv
`timescale 1ns/1ns
module testbench;
  import bhdp_pkg::*;
  logic ref_clk, rst_n, reg_wr, reg_rd, direction_select, gpio1_i;
  logic [5:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [7:0]  interp_factor, decim_factor;
  logic [15:0] bus_in, bus_out, word_i, word_q;
  logic [1:0]  gpio_o, gpio_oe;
  logic        oe, half_drive, port_clock, frame_sync;
  bhdp_iq_s    rx_sample, tx_sample;
  logic [15:0] exp_q[$];  // Expected receive words in order.
  int n_errors, num_checks;
  logic seen_fs, armed;

  bhdp_top bhdp_top_inst (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .interp_factor(interp_factor), .decim_factor(decim_factor), .rx_sample(rx_sample),
    .tx_sample(tx_sample), .host_data_port_i(bus_in), .host_data_port_o(bus_out),
    .host_data_port_oe(oe), .port_half_drive(half_drive),
    .direction_select(direction_select), .port_clock(port_clock),
    .frame_sync(frame_sync), .gpio1_i(gpio1_i), .gpio_o(gpio_o), .gpio_oe(gpio_oe));
  bhdp_host_model bhdp_host_model_inst (.ref_clk(ref_clk),
    .direction_select(direction_select), .port_clock(port_clock),
    .frame_sync(frame_sync), .word_i(word_i), .word_q(word_q), .host_data_port_i(bus_in));

  // 100 MHz master clock.
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Register write and read, one strobe cycle each.
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge ref_clk); #1;
    reg_addr = a; reg_wdata = d; reg_wr = 1'b1;
    @(posedge ref_clk); #1;
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge ref_clk); #1;
    reg_addr = a; reg_rd = 1'b1;
    @(posedge ref_clk); #1;
    reg_rd = 1'b0;
    chk(reg_rdata, e);
  endtask

  // Bounded waits: for the queue to drain, or for a serial bit clock.
  task automatic wait_drain();
    int k;
    for (k = 0; k < 200 && exp_q.size() > 0; k++) @(posedge ref_clk);
    if (exp_q.size() > 0) begin n_errors++; test_done(); end
    #1;
  endtask

  task automatic wait_bclk();
    int k;
    for (k = 0; k < 50; k++) begin
      @(posedge ref_clk); #1;
      if (gpio_o[0] === 1'b1) break;
    end
    if (k == 50) begin n_errors++; test_done(); end
  endtask

  // Monitor: after the sync fall each port clock pulse carries a word.
  always @(posedge ref_clk) begin
    #1;
    if (direction_select || !rst_n) begin
      seen_fs = 1'b0; armed = 1'b0;
    end else if (port_clock && frame_sync) begin
      seen_fs = 1'b1; armed = 1'b0;
    end else if (port_clock && seen_fs && !armed) begin
      armed = 1'b1;  // Sync fall tick carries no word.
    end else if (port_clock && armed && exp_q.size() > 0) begin
      chk(oe, 1'b1);
      chk(bus_out, exp_q.pop_front());
    end
  end

  // Main sequence.
  initial begin
    logic [15:0] mx, mn;
    void'($urandom(97));
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, gpio1_i} = '0;
    {seen_fs, armed, n_errors, num_checks} = '0;
    direction_select = 1'b0;
    interp_factor = 8'h04; decim_factor = 8'h04;
    rx_sample = bhdp_iq_s'($urandom);
    word_i = 16'($urandom); word_q = 16'($urandom);
    mx = 16'($urandom); mn = 16'($urandom);
    repeat (6) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    rd(6'h00, 8'h40);
    chk(oe, 1'b0);
    rd(6'h01, 8'h00);
    wr(6'h0c, mx[15:8]); wr(6'h0d, mx[7:0]); wr(6'h0e, mn[15:8]); wr(6'h0f, mn[7:0]);
    rd(6'h0c, mx[15:8]);
    rd(6'h0f, mn[7:0]);
    rd(6'h3f, 8'h00);
    wr(6'h21, 8'h01);
    chk(half_drive, 1'b1);
    // Receive burst of two I/Q pairs.
    exp_q = '{rx_sample.i, rx_sample.q, rx_sample.i, rx_sample.q};
    wr(6'h00, 8'h00);
    wait_drain();
    // Transmit burst, then back to receive with the sample held.
    direction_select = 1'b1;
    @(posedge ref_clk); #1;
    chk(oe, 1'b0);
    repeat (40) @(posedge ref_clk);
    #1 chk(tx_sample, {word_i, word_q});
    direction_select = 1'b0;
    repeat (40) @(posedge ref_clk);
    #1 chk(tx_sample, {word_i, word_q});
    // Address preamble: first word holds the top address bits.
    wr(6'h18, 8'h55);
    wr(6'h01, 8'h04);
    chk(gpio_oe, 2'h3);
    direction_select = 1'b1;
    @(posedge ref_clk); #1;
    exp_q = '{16'h0005};
    direction_select = 1'b0;
    wait_drain();
    chk(gpio_o, 2'h0);
    repeat (8) @(posedge ref_clk);
    #1 chk(gpio_o, 2'h1);
    chk(oe, 1'b1);
    wr(6'h00, 8'h40);
    chk(oe, 1'b0);
    // Serial on-off keyed input.
    wr(6'h01, 8'h01);
    chk(gpio_oe, 2'h1);
    gpio1_i = 1'b1;
    wait_bclk(); wait_bclk();
    chk(tx_sample, {mx, 16'h0000});
    gpio1_i = 1'b0;
    wait_bclk(); wait_bclk();
    chk(tx_sample, {mn, 16'h0000});
    test_done();
  end
endmodule  // testbench
